// >>> ubb_user_bit_rate_bridge.sv
// user-bit manager carrying u data from the aes3 receiver to the aes3 transmitter
//
// Design decisions made here: the placing of the registers and the APB register port.
`default_nettype none

module ubb_user_bit_rate_bridge #(
    parameter int unsigned BLK_BYTES  = 48,
    parameter int unsigned FIFO_DEPTH = 8
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire ubb_pkg::ubb_apb_req_t apb,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  rx_u_valid,
    input  wire logic                  rx_u_bit,
    input  wire logic                  tx_u_req,
    output logic                       tx_u_bit,
    output logic                       u_ovw_evt
);
    import ubb_pkg::*;

    localparam int unsigned BLK_BITS = BLK_BYTES * 8;
    localparam int unsigned BP_W     = $clog2(BLK_BITS);
    localparam int unsigned BY_W     = BP_W - 3;
    localparam int unsigned UB_WORDS = BLK_BYTES / 2;
    localparam int unsigned FP_W     = $clog2(FIFO_DEPTH);
    localparam int unsigned CNT_W    = FP_W + 1;
    localparam logic [BP_W-1:0]  LAST_POS   = BP_W'(BLK_BITS - 1);
    localparam logic [9:0]       UB_WORDS_C = 10'(UB_WORDS);
    localparam logic [CNT_W-1:0] DEPTH_C    = CNT_W'(FIFO_DEPTH);

    // apb slave
    ubb_mode_t         mode;
    logic              ovw_en;
    logic              ovw_flag;
    logic              len_err;
    logic [31:0]       subcode;
    logic [3:0]        min_if;
    logic [CNT_W-1:0]  count;
    logic [7:0]        ebuf [BLK_BYTES];
    logic [11:0]       ub_off;
    logic              ub_hit;
    logic              reg_hit;
    logic [BY_W-1:0]   ub_byte;
    logic              setup_ph;
    logic              wr_acc;
    logic [31:0]       next_prdata;

    assign setup_ph = apb.psel & ~apb.penable;
    assign wr_acc   = apb.psel & apb.penable & apb.pwrite;
    assign ub_off   = apb.paddr - REG_UBUF;
    assign ub_hit   = (apb.paddr >= REG_UBUF) && (ub_off[11:2] < UB_WORDS_C)
                      && (ub_off[1:0] == 2'b00);
    assign ub_byte  = BY_W'({ub_off[11:2], 1'b0});
    assign reg_hit  = ub_hit || (apb.paddr == REG_CTRL) || (apb.paddr == REG_STATUS)
                      || (apb.paddr == REG_SUBCODE) || (apb.paddr == REG_FILLER);
    // zero-wait slave: the answer is ready in the first access cycle
    assign pready   = 1'b1;
    assign pslverr  = apb.psel & apb.penable & ~reg_hit;

    always_comb
    begin
        next_prdata = 32'h0000_0000;
        if (ub_hit)
        begin
            next_prdata[15:8] = ebuf[ub_byte];
            next_prdata[7:0]  = ebuf[ub_byte + BY_W'(1)];
        end
        else if (apb.paddr == REG_CTRL)
        begin
            next_prdata[CTRL_MODE_LSB +: 2] = mode;
            next_prdata[CTRL_OVW_EN_BIT]    = ovw_en;
        end
        else if (apb.paddr == REG_STATUS)
        begin
            next_prdata[STAT_OVW_BIT]            = ovw_flag;
            next_prdata[STAT_LEN_BIT]            = len_err;
            next_prdata[STAT_LEVEL_LSB +: CNT_W] = count;
        end
        else if (apb.paddr == REG_SUBCODE)
        begin
            next_prdata = subcode;
        end
        else if (apb.paddr == REG_FILLER)
        begin
            next_prdata[3:0] = min_if;
        end
    end

    // read data is captured in the setup cycle so it stands through the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup_ph && !apb.pwrite)
            prdata <= next_prdata;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode   <= UBB_ZEROS;
            ovw_en <= 1'b0;
        end
        else if (wr_acc && apb.paddr == REG_CTRL)
        begin
            mode   <= ubb_mode_t'(apb.pwdata[CTRL_MODE_LSB +: 2]);
            ovw_en <= apb.pwdata[CTRL_OVW_EN_BIT];
        end
    end

    logic cons;
    logic mode_b;
    assign cons   = (mode == UBB_CONS_A) || (mode == UBB_CONS_B);
    assign mode_b = (mode == UBB_CONS_B);

    // block mode: d -> e -> f
    logic [7:0]      dbuf [BLK_BYTES];
    logic [7:0]      fbuf [BLK_BYTES];
    logic [BP_W-1:0] d_pos;
    logic [BP_W-1:0] f_pos;
    logic            d_to_e;
    logic            e_to_f;
    logic [7:0]      d_last_byte;
    logic            blk_rx;
    logic            blk_tx;

    assign blk_rx = rx_u_valid && (mode == UBB_BLOCK);
    assign blk_tx = tx_u_req && (mode == UBB_BLOCK);
    assign d_to_e = blk_rx && (d_pos == LAST_POS);
    assign e_to_f = blk_tx && (f_pos == LAST_POS);

    always_comb
    begin
        d_last_byte = dbuf[d_pos[BP_W-1:3]];
        d_last_byte[3'h7 - d_pos[2:0]] = rx_u_bit;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            d_pos <= '0;
            for (int i = 0; i < BLK_BYTES; i++)
                dbuf[i] <= 8'h00;
        end
        else if (mode != UBB_BLOCK)
            d_pos <= '0;
        else if (blk_rx)
        begin
            dbuf[d_pos[BP_W-1:3]] <= d_last_byte;
            d_pos <= d_to_e ? '0 : d_pos + BP_W'(1);
        end
    end

    // a host write lands after a same-cycle block copy, so the host value is kept
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < BLK_BYTES; i++)
                ebuf[i] <= 8'h00;
        end
        else
        begin
            if (d_to_e)
            begin
                for (int i = 0; i < BLK_BYTES; i++)
                    ebuf[i] <= (BY_W'(i) == d_pos[BP_W-1:3]) ? d_last_byte : dbuf[i];
            end
            if (wr_acc && ub_hit)
            begin
                ebuf[ub_byte]              <= apb.pwdata[15:8];
                ebuf[ub_byte + BY_W'(1)]   <= apb.pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            f_pos <= '0;
            for (int i = 0; i < BLK_BYTES; i++)
                fbuf[i] <= 8'h00;
        end
        else if (mode != UBB_BLOCK)
            f_pos <= '0;
        else if (blk_tx)
        begin
            f_pos <= e_to_f ? '0 : f_pos + BP_W'(1);
            if (e_to_f)
            begin
                for (int i = 0; i < BLK_BYTES; i++)
                    fbuf[i] <= ebuf[i];
            end
        end
    end

    // consumer receive parser
    logic       rx_in_unit;
    logic [2:0] rx_bitcnt;
    logic [7:0] rx_shift;
    logic [3:0] rx_zeros;
    logic       rx_msg_open;
    logic [7:0] rx_units;
    logic       rx_ev;
    logic       unit_done;
    logic       gap_hit;
    logic       start_hit;
    logic [7:0] unit_word;

    assign rx_ev     = rx_u_valid && cons;
    assign unit_done = rx_ev && rx_in_unit && (rx_bitcnt == UNIT_LAST_BIT);
    assign unit_word = {rx_shift[6:0], rx_u_bit};
    assign start_hit = rx_ev && !rx_in_unit && rx_u_bit;
    assign gap_hit   = rx_ev && !rx_in_unit && !rx_u_bit && rx_msg_open
                       && (rx_zeros == GAP_ZEROS - 4'h1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_in_unit  <= 1'b0;
            rx_bitcnt   <= 3'h0;
            rx_shift    <= 8'h00;
            rx_zeros    <= GAP_ZEROS;
            rx_msg_open <= 1'b0;
            rx_units    <= 8'h00;
        end
        else if (!cons)
        begin
            rx_in_unit  <= 1'b0;
            rx_zeros    <= GAP_ZEROS;
            rx_msg_open <= 1'b0;
            rx_units    <= 8'h00;
        end
        else if (rx_ev)
        begin
            if (rx_in_unit)
            begin
                rx_shift  <= unit_word;
                rx_bitcnt <= rx_bitcnt + 3'h1;
                if (unit_done)
                begin
                    rx_in_unit  <= 1'b0;
                    rx_zeros    <= 4'h0;
                    rx_msg_open <= 1'b1;
                    rx_units    <= (rx_units == 8'hFF) ? rx_units : rx_units + 8'h01;
                end
            end
            else if (rx_u_bit)
            begin
                rx_in_unit <= 1'b1;
                rx_shift  <= 8'h01;
                rx_bitcnt <= 3'h1;
            end
            else
            begin
                if (rx_zeros != GAP_ZEROS)
                    rx_zeros <= rx_zeros + 4'h1;
                if (gap_hit)
                begin
                    rx_msg_open <= 1'b0;
                    rx_units    <= 8'h00;
                end
            end
        end
    end

    // subcode gathers the bit after each start bit, oldest bit highest
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            subcode <= SUBCODE_RESET;
        else if (rx_ev && rx_in_unit && rx_bitcnt == Q_BIT_COUNT)
            subcode <= {subcode[30:0], rx_u_bit};
    end

    // shortest inter-unit filler seen inside a message
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            min_if <= FILLER_RESET;
        else if (start_hit && rx_msg_open && rx_zeros < min_if)
            min_if <= rx_zeros;
    end

    // unit fifo
    ubb_entry_t       mem [FIFO_DEPTH];
    logic [FP_W-1:0]  wr_ptr;
    logic [FP_W-1:0]  rd_ptr;
    logic [CNT_W-1:0] complete;
    logic             pop;
    logic             push;
    logic             ovw;
    logic             flush;
    logic             can_start;
    ubb_tx_state_t    tx_state;
    logic             tx_in_msg;

    // only completed units are pushed, so zeros never occupy the fifo
    assign push  = unit_done;
    assign ovw   = push && (count == DEPTH_C) && !pop;
    assign flush = !cons || (ovw && mode_b);
    assign can_start = (count != '0) && (!mode_b || complete != '0 || tx_in_msg);
    assign pop   = tx_u_req && cons && (tx_state == TX_IDLE) && can_start;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            count    <= '0;
            complete <= '0;
            for (int i = 0; i < FIFO_DEPTH; i++)
                mem[i] <= '0;
        end
        else if (flush)
        begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            count    <= '0;
            complete <= '0;
        end
        else
        begin
            if (push)
            begin
                mem[wr_ptr] <= '{last: 1'b0, unit: unit_word};
                wr_ptr      <= wr_ptr + FP_W'(1);
            end
            // variable mode overwrite drops the oldest unit to keep the stream moving
            if (ovw)
                rd_ptr <= rd_ptr + FP_W'(1);
            else if (pop)
                rd_ptr <= rd_ptr + FP_W'(1);
            if (push && !pop && !ovw)
                count <= count + CNT_W'(1);
            else if (pop && !push)
                count <= count - CNT_W'(1);
            if (gap_hit && count != '0 && mode_b)
                mem[wr_ptr - FP_W'(1)].last <= 1'b1;
            if (mode_b)
            begin
                if ((gap_hit && count != '0) && !(pop && mem[rd_ptr].last))
                    complete <= complete + CNT_W'(1);
                else if (!(gap_hit && count != '0) && pop && mem[rd_ptr].last)
                    complete <= complete - CNT_W'(1);
            end
        end
    end

    // sticky status: a new event in the clearing cycle stays set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ovw_flag  <= 1'b0;
            len_err   <= 1'b0;
            u_ovw_evt <= 1'b0;
        end
        else
        begin
            u_ovw_evt <= ovw && ovw_en;
            if (ovw)
                ovw_flag <= 1'b1;
            else if (wr_acc && apb.paddr == REG_STATUS && apb.pwdata[STAT_OVW_BIT])
                ovw_flag <= 1'b0;
            if (gap_hit && (rx_units < MSG_MIN_UNITS || rx_units > MSG_MAX_UNITS))
                len_err <= 1'b1;
            else if (wr_acc && apb.paddr == REG_STATUS && apb.pwdata[STAT_LEN_BIT])
                len_err <= 1'b0;
        end
    end

    // transmit side
    logic [7:0] tx_unit;
    logic [2:0] tx_idx;
    logic [3:0] fill_left;
    logic       tx_last;
    logic [7:0] f_byte;

    assign f_byte = fbuf[f_pos[BP_W-1:3]];

    // in variable mode the gap after a unit is whatever the fifo timing leaves,
    // so output filler tracks the rate ratio and long fills go unnoticed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_u_bit  <= 1'b0;
            tx_state  <= TX_IDLE;
            tx_unit   <= 8'h00;
            tx_idx    <= 3'h0;
            fill_left <= 4'h0;
            tx_last   <= 1'b0;
            tx_in_msg <= 1'b0;
        end
        else if (!cons)
        begin
            tx_state  <= TX_IDLE;
            tx_in_msg <= 1'b0;
            if (tx_u_req)
                tx_u_bit <= (mode == UBB_BLOCK) ? f_byte[3'h7 - f_pos[2:0]] : 1'b0;
        end
        else
        begin
            if (flush)
                tx_in_msg <= 1'b0;
            if (tx_u_req)
            begin
                unique case (tx_state)
                    TX_IDLE:
                    begin
                        tx_u_bit <= 1'b0;
                        if (can_start)
                        begin
                            tx_u_bit  <= mem[rd_ptr].unit[7];
                            tx_unit   <= mem[rd_ptr].unit;
                            tx_last   <= mem[rd_ptr].last;
                            tx_in_msg <= mode_b && !mem[rd_ptr].last;
                            tx_idx    <= 3'h6;
                            tx_state  <= TX_UNIT;
                        end
                    end
                    TX_UNIT:
                    begin
                        tx_u_bit <= tx_unit[tx_idx];
                        tx_idx   <= tx_idx - 3'h1;
                        if (tx_idx == 3'h0)
                        begin
                            if (mode_b && !tx_last && min_if != 4'h0)
                            begin
                                fill_left <= min_if;
                                tx_state  <= TX_FILL;
                            end
                            else
                                tx_state <= TX_IDLE;
                        end
                    end
                    TX_FILL:
                    begin
                        tx_u_bit  <= 1'b0;
                        fill_left <= fill_left - 4'h1;
                        if (fill_left == 4'h1)
                            tx_state <= TX_IDLE;
                    end
                    default:
                        tx_state <= TX_IDLE;
                endcase
            end
        end
    end

endmodule : ubb_user_bit_rate_bridge

`default_nettype wire

// >>> ubb_pkg.sv
// constants and types shared by the user-bit rate bridge
`default_nettype none

package ubb_pkg;

    // register byte offsets on the apb window
    localparam logic [11:0] REG_CTRL    = 12'h000;
    localparam logic [11:0] REG_STATUS  = 12'h004;
    localparam logic [11:0] REG_SUBCODE = 12'h008;
    localparam logic [11:0] REG_FILLER  = 12'h00C;
    localparam logic [11:0] REG_UBUF    = 12'h040;

    // field positions
    localparam int unsigned CTRL_MODE_LSB   = 0;
    localparam int unsigned CTRL_OVW_EN_BIT = 2;
    localparam int unsigned STAT_OVW_BIT    = 0;
    localparam int unsigned STAT_LEN_BIT    = 1;
    localparam int unsigned STAT_LEVEL_LSB  = 8;

    // reset values
    localparam logic [3:0]  FILLER_RESET  = 4'h8;
    localparam logic [31:0] SUBCODE_RESET = 32'h0000_0000;

    // consumer message format
    localparam logic [2:0] UNIT_LAST_BIT = 3'h7;
    localparam logic [2:0] Q_BIT_COUNT   = 3'h1;
    localparam logic [3:0] GAP_ZEROS     = 4'h9;
    localparam logic [7:0] MSG_MIN_UNITS = 8'h03;
    localparam logic [7:0] MSG_MAX_UNITS = 8'h81;

    typedef enum logic [1:0]
    {
        UBB_ZEROS  = 2'b00,
        UBB_BLOCK  = 2'b01,
        UBB_CONS_A = 2'b10,
        UBB_CONS_B = 2'b11
    } ubb_mode_t;

    typedef enum logic [1:0]
    {
        TX_IDLE = 2'b00,
        TX_UNIT = 2'b01,
        TX_FILL = 2'b10
    } ubb_tx_state_t;

    typedef struct packed
    {
        logic       last;
        logic [7:0] unit;
    } ubb_entry_t;

    typedef struct packed
    {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ubb_apb_req_t;

endpackage : ubb_pkg

`default_nettype wire

// >>> ubb_properties.sv
// port assertions for the user-bit rate bridge
`default_nettype none

module ubb_properties #(
    parameter int unsigned BLK_BYTES = 48
) (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire ubb_pkg::ubb_apb_req_t apb,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  rx_u_valid,
    input wire logic                  rx_u_bit,
    input wire logic                  tx_u_req,
    input wire logic                  tx_u_bit,
    input wire logic                  u_ovw_evt
);
    import ubb_pkg::*;

    ubb_mode_t mode_q;
    logic      ovw_en_q;

    // shadow of the control field: the mode is not visible at the ports
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q   <= UBB_ZEROS;
            ovw_en_q <= 1'b0;
        end
        else if (apb.psel && apb.penable && apb.pwrite && pready && apb.paddr == REG_CTRL)
        begin
            mode_q   <= ubb_mode_t'(apb.pwdata[1:0]);
            ovw_en_q <= apb.pwdata[CTRL_OVW_EN_BIT];
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_zero_mode_out: assert property (
        tx_u_req && mode_q == UBB_ZEROS |=> !tx_u_bit)
        else $error("user bit not zero in zero mode");
    chk_evt_enabled: assert property (
        u_ovw_evt |-> $past(ovw_en_q) && ($past(mode_q) inside {UBB_CONS_A, UBB_CONS_B}))
        else $error("overwrite event while disabled");
    chk_evt_single: assert property (
        u_ovw_evt |=> !u_ovw_evt [*7])
        else $error("overwrite event longer than one cycle");
    chk_evt_from_rx: assert property (
        u_ovw_evt |-> $past(rx_u_valid) || $past(rx_u_valid, 2))
        else $error("overwrite event without a received bit");
    chk_ctrl_no_err: assert property (
        apb.psel && apb.penable && apb.paddr == REG_CTRL |-> pready && !pslverr)
        else $error("control access refused");
    chk_ubuf_no_err: assert property (
        apb.psel && apb.penable && apb.paddr >= REG_UBUF
        && apb.paddr < REG_UBUF + 12'(2 * BLK_BYTES)
        && apb.paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("user buffer access refused");
    chk_err_access_only: assert property (
        pslverr |-> apb.psel && apb.penable)
        else $error("error outside access phase");
    chk_rdata_hold: assert property (
        !$past(apb.psel && !apb.penable && !apb.pwrite) |-> $stable(prdata))
        else $error("read data changed without a read");

endmodule : ubb_properties

bind ubb_user_bit_rate_bridge ubb_properties #(
    .BLK_BYTES(BLK_BYTES)
) u_ubb_properties (
    .pclk       (pclk),
    .presetn    (presetn),
    .apb        (apb),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .rx_u_valid (rx_u_valid),
    .rx_u_bit   (rx_u_bit),
    .tx_u_req   (tx_u_req),
    .tx_u_bit   (tx_u_bit),
    .u_ovw_evt  (u_ovw_evt)
);

`default_nettype wire

// >>> ubb_link_model.sv
// model of the aes3 receiver and transmitter around the bridge
`default_nettype none

module ubb_link_model (
    input  wire logic pclk,
    input  wire logic tx_u_bit,
    output logic      rx_u_valid,
    output logic      rx_u_bit,
    output logic      tx_u_req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        rx_u_valid = 1'b0;
        rx_u_bit   = 1'b0;
        tx_u_req   = 1'b0;
    end

    // msb first; the data line flips when not valid so stale bits never look held
    task automatic send_bits(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            @(posedge pclk);
            rx_u_valid <= 1'b1;
            rx_u_bit   <= v[i];
            @(posedge pclk);
            rx_u_valid <= 1'b0;
            rx_u_bit   <= ~v[i];
        end
    endtask : send_bits

    task automatic take_bits(output logic [31:0] v, input int n);
        v = '0;
        for (int i = 0; i < n; i++)
        begin
            @(posedge pclk);
            tx_u_req <= 1'b1;
            @(posedge pclk);
            tx_u_req <= 1'b0;
            @(posedge pclk);
            v = {v[30:0], tx_u_bit};
        end
    endtask : take_bits

endmodule : ubb_link_model

`default_nettype wire

// >>> tb.sv
// self-checking bench for the user-bit rate bridge
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ubb_pkg::*;

    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    ubb_apb_req_t apb = '0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         rx_u_valid;
    logic         rx_u_bit;
    logic         tx_u_req;
    logic         tx_u_bit;
    logic         u_ovw_evt;
    logic [31:0]  v;
    logic [31:0]  d;
    logic         e;
    int           error_cnt = 0;
    int           n_compared = 0;
    int           cycles = 0;
    int           evt_cnt = 0;

    ubb_user_bit_rate_bridge #(.BLK_BYTES(4), .FIFO_DEPTH(4)) u_ubb_user_bit_rate_bridge (
        .pclk       (pclk),
        .presetn    (presetn),
        .apb        (apb),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .rx_u_valid (rx_u_valid),
        .rx_u_bit   (rx_u_bit),
        .tx_u_req   (tx_u_req),
        .tx_u_bit   (tx_u_bit),
        .u_ovw_evt  (u_ovw_evt)
    );

    ubb_link_model u_ubb_link_model (
        .pclk       (pclk),
        .tx_u_bit   (tx_u_bit),
        .rx_u_valid (rx_u_valid),
        .rx_u_bit   (rx_u_bit),
        .tx_u_req   (tx_u_req)
    );

    always #10 pclk = ~pclk;

    always @(posedge pclk)
    begin
        cycles++;
        evt_cnt += int'(u_ovw_evt === 1'b1);
        if (cycles == 5000)
        begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (error_cnt == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                            output logic [31:0] rd, output logic err);
        @(posedge pclk);
        apb <= {1'b1, 1'b0, wr, a, wd};
        @(posedge pclk);
        apb.penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        apb <= '0;
    endtask : apb_xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        apb_xfer(1'b1, a, wd, d, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb_xfer(1'b0, a, 32'h0, d, e);
        check(d, exp);
    endtask : rd

    task automatic send_unit(input logic [7:0] u, input int fill);
        u_ubb_link_model.send_bits({24'h0, u}, 8);
        u_ubb_link_model.send_bits(32'h0, fill);
    endtask : send_unit

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(REG_CTRL, 32'h0);
        rd(REG_FILLER, 32'h8);
        rd(REG_SUBCODE, 32'h0);
        apb_xfer(1'b0, 12'h3F0, 32'h0, d, e);
        check({31'h0, e}, 32'h1);
        u_ubb_link_model.send_bits(32'hFF, 8);
        u_ubb_link_model.take_bits(v, 8);
        check(v, 32'h0);
        wr(REG_CTRL, 32'h1);
        wr(REG_UBUF, 32'hA5C3);
        wr(REG_UBUF + 12'h4, 32'h1234);
        rd(REG_UBUF, 32'hA5C3);
        u_ubb_link_model.take_bits(v, 32);
        u_ubb_link_model.take_bits(v, 32);
        check(v, 32'hA5C31234);
        u_ubb_link_model.send_bits(32'h5A0F817E, 32);
        rd(REG_UBUF, 32'h5A0F);
        rd(REG_UBUF + 12'h4, 32'h817E);
        // variable filler: output filler is whatever the fifo timing leaves
        wr(REG_CTRL, 32'h2);
        send_unit(8'hC5, 2);
        send_unit(8'hAB, 3);
        u_ubb_link_model.take_bits(v, 20);
        check(v, 32'h000C5AB0);
        rd(REG_SUBCODE, 32'h2);
        wr(REG_CTRL, 32'h6);
        for (int i = 1; i <= 5; i++)
            send_unit(8'h80 + 8'(i), 3);
        check(32'(evt_cnt), 32'h1);
        rd(REG_STATUS, 32'h401);
        wr(REG_STATUS, 32'h1);
        rd(REG_STATUS, 32'h400);
        u_ubb_link_model.take_bits(v, 32);
        check(v, 32'h82838485);
        // fixed filler: whole message first, then gap padding
        wr(REG_CTRL, 32'h7);
        send_unit(8'hC5, 2);
        send_unit(8'hAB, 2);
        send_unit(8'h9E, 0);
        u_ubb_link_model.take_bits(v, 8);
        check(v, 32'h0);
        u_ubb_link_model.send_bits(32'h0, 9);
        rd(REG_FILLER, 32'h2);
        rd(REG_STATUS, 32'h300);
        u_ubb_link_model.take_bits(v, 32);
        check(v, 32'hC52AC9E0);
        send_unit(8'hF0, 9);
        apb_xfer(1'b0, REG_STATUS, 32'h0, d, e);
        check(d & 32'h3, 32'h2);
        wr(REG_STATUS, 32'h2);
        for (int i = 1; i <= 5; i++)
            send_unit(8'h90 + 8'(i), 2);
        check(32'(evt_cnt), 32'h2);
        apb_xfer(1'b0, REG_STATUS, 32'h0, d, e);
        check(d & 32'h1, 32'h1);
        u_ubb_link_model.take_bits(v, 8);
        check(v, 32'h0);
        stop_test();
    end

endmodule : tb

`default_nettype wire
